// ==== sndp_cfg.svh ====
`ifndef SNDP_CFG_SVH
`define SNDP_CFG_SVH

// command codes
`define SNDP_CMD_SLEEP       8'hb9
`define SNDP_CMD_WAKE        8'hab
`define SNDP_CMD_SOFT_RESET  8'hff
`define SNDP_CMD_RESET_EN    8'h66
`define SNDP_CMD_RESET       8'h99

// bits in one command byte
`define SNDP_CMD_BITS        4'd8

// core clock and delays
`define SNDP_CLK_MHZ         10
`define SNDP_SLEEP_ENTRY_NS  3000
`define SNDP_WAKE_NS         30000
// longest times round down to whole cycles, with no floor of one cycle
`define SNDP_SLEEP_ENTRY_CYC ((`SNDP_SLEEP_ENTRY_NS * `SNDP_CLK_MHZ) / 1000)
`define SNDP_WAKE_CYC        ((`SNDP_WAKE_NS * `SNDP_CLK_MHZ) / 1000)

`endif

// ==== sndp_pkg.sv ====
package sndp_pkg;

    typedef enum logic [2:0] {
        ST_STANDBY  = 3'b000,
        ST_ENTERING = 3'b001,
        ST_SLEEP    = 3'b010,
        ST_WAKING   = 3'b011,
        ST_RESETTING = 3'b100
    } sndp_state_t;

    typedef enum logic [1:0] {
        HS_IDLE  = 2'b00,
        HS_SHIFT = 2'b01,
        HS_GAP   = 2'b10
    } sndp_hstate_t;

endpackage

// ==== sndp_if.sv ====
`timescale 1ns/1ps
// serial command link: host drives select, clock strobe and data bit
interface sndp_if;
    logic cs_n;      // chip select, active low
    logic sclk_en;   // one-cycle strobe: data bit valid, latch it
    logic sdi;       // serial data, msb first
    logic busy;      // operation in progress seen by host

    modport dev  (input cs_n, input sclk_en, input sdi, output busy);
    modport host (output cs_n, output sclk_en, output sdi, input busy);
endinterface

// ==== sndp_host.sv ====
`timescale 1ns/1ps
`include "sndp_cfg.svh"
// host end: sends one command byte per chip-select frame
module sndp_host (
    input  wire logic CORE_CLK,
    input  wire logic NRST,
    sndp_if.host      LINK,
    input  wire logic CMD_VALID,
    input  wire logic [7:0] CMD_BYTE,
    output logic      CMD_READY,
    output logic      CMD_DONE,
    output logic      DEV_BUSY
);
    sndp_pkg::sndp_hstate_t st_q;
    logic [7:0]  sh_q;
    logic [7:0]  byte_q;
    logic [3:0]  bit_q;
    logic [15:0] gap_q;
    logic        cs_n_q;
    logic        stb_q;
    logic        done_q;
    logic        busy_q;

    wire last_bit  = (bit_q == `SNDP_CMD_BITS - 4'd1);
    // the shifter is spent by the last bit, so decode the copy taken at frame start
    wire is_wake   = (byte_q == `SNDP_CMD_WAKE);
    // after wake, hold select high for the whole wake delay
    wire [15:0] gap_len = is_wake ? 16'(`SNDP_WAKE_CYC) : 16'h0001;
    wire gap_done  = (gap_q == 16'h0000);

    assign CMD_READY  = (st_q == sndp_pkg::HS_IDLE);
    assign CMD_DONE   = done_q;
    assign DEV_BUSY   = busy_q;
    assign LINK.cs_n  = cs_n_q;
    assign LINK.sclk_en = stb_q;
    assign LINK.sdi   = sh_q[7];

    // frame: select low, eight strobed bits, select high right after the eighth
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            st_q   <= sndp_pkg::HS_IDLE;
            sh_q   <= 8'h00;
            byte_q <= 8'h00;
            bit_q  <= 4'h0;
            gap_q  <= 16'h0000;
            cs_n_q <= 1'b1;
            stb_q  <= 1'b0;
            done_q <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            done_q <= 1'b0;
            busy_q <= LINK.busy;
            unique case (st_q)
                sndp_pkg::HS_IDLE: begin
                    if (CMD_VALID) begin
                        sh_q   <= CMD_BYTE;
                        byte_q <= CMD_BYTE;
                        cs_n_q <= 1'b0;
                        stb_q  <= 1'b1;
                        bit_q  <= 4'h0;
                        st_q   <= sndp_pkg::HS_SHIFT;
                    end
                end
                sndp_pkg::HS_SHIFT: begin
                    if (last_bit) begin
                        stb_q  <= 1'b0;
                        cs_n_q <= 1'b1;
                        gap_q  <= gap_len - 16'h0001;
                        st_q   <= sndp_pkg::HS_GAP;
                    end else begin
                        sh_q  <= {sh_q[6:0], 1'b0};
                        bit_q <= bit_q + 4'd1;
                    end
                end
                sndp_pkg::HS_GAP: begin
                    if (gap_done) begin
                        done_q <= 1'b1;
                        st_q   <= sndp_pkg::HS_IDLE;
                    end else begin
                        gap_q <= gap_q - 16'h0001;
                    end
                end
                default: st_q <= sndp_pkg::HS_IDLE;
            endcase
        end
    end
endmodule

// ==== sndp_dev.sv ====
`timescale 1ns/1ps
`include "sndp_cfg.svh"
// Summary of operation
// - only the sleep command enters deep sleep
// - deep sleep drops write, program, erase commands
// - plain deselect gives standby, never deep sleep
// - asleep, only wake and resets are honoured
// - power-on reset always lands in standby
// - sleep runs only if select rises after bit eight; the device here also runs it after bit 18, 28 and so on
// - sleep entry waits the entry delay
// - sleep refused while array cycle busy
// - host wakes with a one-byte select frame
// - no command accepted during the wake delay
// - wake ignored while array cycle busy
// - host checks busy flag after waking; the host here only passes busy out on DEV_BUSY
// - reset pair ends sleep, restores power-on settings
// - entry delay at most 3 us
// - wake delay at most 30 us
module sndp_dev (
    input  wire logic CORE_CLK,
    input  wire logic NRST,
    sndp_if.dev       LINK,
    input  wire logic ARRAY_BUSY,
    output logic      CMD_STB,
    output logic [7:0] CMD_CODE,
    output logic      SOFT_RESET,
    output logic      POR_RESET,
    output logic      DEEP_SLEEP,
    output logic      LOW_POWER,
    output logic      CMD_BLOCKED
);
    sndp_pkg::sndp_state_t st_q;
    logic [7:0]  sh_q;
    logic [3:0]  cnt_q;
    logic        cs_n_q;
    logic        rst_armed_q;
    logic [15:0] tmr_q;
    logic        stb_q;
    logic [7:0]  code_q;
    logic        srst_q;
    logic        por_q;

    // frame tracking: the byte is complete once eight bits are in
    wire [7:0] sh_next   = {sh_q[6:0], LINK.sdi};
    wire       byte_full = (cnt_q == `SNDP_CMD_BITS);
    wire       cs_rise   = LINK.cs_n & ~cs_n_q;
    // a byte ends cleanly only when select rises with the count at eight: after 8 bits, or 18, 28 and so on once it wraps
    wire       frame_end = cs_rise & byte_full;
    wire       tmr_zero  = (tmr_q == 16'h0000);

    wire is_sleep = (sh_q == `SNDP_CMD_SLEEP);
    wire is_wake  = (sh_q == `SNDP_CMD_WAKE);
    wire is_srst  = (sh_q == `SNDP_CMD_SOFT_RESET);
    wire is_ren   = (sh_q == `SNDP_CMD_RESET_EN);
    wire is_rst   = (sh_q == `SNDP_CMD_RESET);
    wire asleep   = (st_q == sndp_pkg::ST_SLEEP) | (st_q == sndp_pkg::ST_ENTERING);
    wire reset_go = is_rst & rst_armed_q;

    // which complete frames do what
    wire do_sleep = frame_end & is_sleep & ~ARRAY_BUSY & (st_q == sndp_pkg::ST_STANDBY);
    wire do_wake  = frame_end & is_wake & ~ARRAY_BUSY & asleep;
    wire do_srst  = frame_end & is_srst & (st_q != sndp_pkg::ST_WAKING);
    wire do_por   = frame_end & reset_go & (st_q != sndp_pkg::ST_WAKING);
    // other commands pass on only in standby; asleep or waking they are dropped
    wire pass_cmd = frame_end & (st_q == sndp_pkg::ST_STANDBY) & ~is_sleep;

    assign CMD_STB     = stb_q;
    assign CMD_CODE    = code_q;
    assign SOFT_RESET  = srst_q;
    assign POR_RESET   = por_q;
    assign DEEP_SLEEP  = (st_q == sndp_pkg::ST_SLEEP);
    assign LOW_POWER   = (st_q == sndp_pkg::ST_SLEEP);
    assign CMD_BLOCKED = (st_q != sndp_pkg::ST_STANDBY);
    assign LINK.busy   = ARRAY_BUSY;

    // count clears while select stays high past its rise cycle; a ninth bit sets the count to 15, a tenth wraps it to 0
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            sh_q   <= 8'h00;
            cnt_q  <= 4'h0;
            cs_n_q <= 1'b1;
        end else begin
            cs_n_q <= LINK.cs_n;
            if (LINK.cs_n) begin
                if (cs_rise) cnt_q <= cnt_q; // keep byte for the frame_end decode
                else cnt_q <= 4'h0;
            end else if (LINK.sclk_en) begin
                sh_q  <= sh_next;
                cnt_q <= byte_full ? 4'hf : cnt_q + 4'd1; // ninth bit spoils frame
            end
        end
    end

    // reset-enable must be the frame directly before reset
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) rst_armed_q <= 1'b0;
        else if (cs_rise) rst_armed_q <= frame_end & is_ren;
    end

    // power state; async reset puts us in standby after power-up
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            st_q  <= sndp_pkg::ST_STANDBY;
            tmr_q <= 16'h0000;
        end else begin
            unique case (st_q)
                sndp_pkg::ST_STANDBY: begin
                    if (do_sleep) begin
                        st_q  <= sndp_pkg::ST_ENTERING;
                        tmr_q <= 16'(`SNDP_SLEEP_ENTRY_CYC) - 16'h0001;
                    end
                end
                sndp_pkg::ST_ENTERING, sndp_pkg::ST_SLEEP: begin
                    if (do_srst | do_por) begin
                        st_q <= sndp_pkg::ST_STANDBY;
                    end else if (do_wake) begin
                        st_q  <= sndp_pkg::ST_WAKING;
                        tmr_q <= 16'(`SNDP_WAKE_CYC) - 16'h0001;
                    end else if (st_q == sndp_pkg::ST_ENTERING) begin
                        if (tmr_zero) st_q <= sndp_pkg::ST_SLEEP;
                        else tmr_q <= tmr_q - 16'h0001;
                    end
                end
                sndp_pkg::ST_WAKING: begin
                    // commands dropped until the wake delay ends
                    if (tmr_zero) st_q <= sndp_pkg::ST_STANDBY;
                    else tmr_q <= tmr_q - 16'h0001;
                end
                default: st_q <= sndp_pkg::ST_STANDBY;
            endcase
        end
    end

    // one-cycle outputs to the core; resets are honoured in any state but waking
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            stb_q  <= 1'b0;
            code_q <= 8'h00;
            srst_q <= 1'b0;
            por_q  <= 1'b0;
        end else begin
            stb_q  <= pass_cmd;
            srst_q <= do_srst;
            por_q  <= do_por;
            if (pass_cmd) code_q <= sh_q;
        end
    end
endmodule

// ==== sndp_chk_sva.sv ====
`timescale 1ns/1ps
// watches the select link and the sleep state of the device end
module sndp_chk (
    input wire logic       CORE_CLK,
    input wire logic       NRST,
    input wire logic       cs_n,
    input wire logic       sclk_en,
    input wire logic       sdi,
    input wire logic       busy,
    input wire logic       CMD_STB,
    input wire logic       POR_RESET,
    input wire logic       DEEP_SLEEP,
    input wire logic       CMD_BLOCKED
);
    logic [7:0] sh_q;
    logic [3:0] n_q;
    logic       cs_q;
    logic       arm_q;
    // byte and bit count of the frame just closed
    wire        whole = n_q == 4'h8;
    wire        keep  = sh_q == 8'hab || sh_q == 8'hff || sh_q == 8'h66 || sh_q == 8'h99;

    // rebuild each frame byte; the count restarts on the first bit after select falls
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            sh_q <= 8'h00;
            n_q <= 4'h0;
            arm_q <= 1'b0;
        end else if (!cs_n && sclk_en) begin
            sh_q <= {sh_q[6:0], sdi};
            n_q <= cs_q ? 4'h1 : n_q + 4'h1;
        end else if (cs_n && !cs_q) begin
            arm_q <= whole && sh_q == 8'h66; // any other frame disarms
        end
    end

    // previous select level, marks first bit and close of a frame
    always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            cs_q <= 1'b1;
        end else begin
            cs_q <= cs_n;
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);

    property p_strobe; sclk_en |-> !cs_n; endproperty
    a_strobe: assert property (p_strobe) else $error("bit strobe outside frame");
    property p_whole; $rose(cs_n) |-> whole; endproperty
    a_whole: assert property (p_whole) else $error("select rose off byte end");
    property p_cause; $rose(CMD_BLOCKED) && sh_q != 8'h99 |-> whole && sh_q == 8'hb9 && !$past(busy);
    endproperty
    a_cause: assert property (p_cause) else $error("left standby without sleep");
    property p_entry; $rose(cs_n) && whole && !CMD_BLOCKED && sh_q == 8'hb9 && !busy
        |-> ##1 (CMD_BLOCKED && !DEEP_SLEEP) ##[1:30] DEEP_SLEEP; endproperty
    a_entry: assert property (p_entry) else $error("sleep entry late");
    property p_drop; $rose(cs_n) && DEEP_SLEEP && !keep |-> ##1 DEEP_SLEEP && !CMD_STB; endproperty
    a_drop: assert property (p_drop) else $error("command taken while asleep");
    property p_wake_busy; $rose(cs_n) && DEEP_SLEEP && sh_q == 8'hab && busy |-> ##1 DEEP_SLEEP;
    endproperty
    a_wake_busy: assert property (p_wake_busy) else $error("wake taken while busy");
    property p_wake; $rose(cs_n) && DEEP_SLEEP && sh_q == 8'hab && !busy
        |-> ##1 (!DEEP_SLEEP && CMD_BLOCKED)[*8] ##[1:295] !CMD_BLOCKED; endproperty
    a_wake: assert property (p_wake) else $error("wake delay wrong");
    property p_por; $rose(cs_n) && arm_q && whole && sh_q == 8'h99 && (DEEP_SLEEP || !CMD_BLOCKED)
        |-> ##1 POR_RESET; endproperty
    a_por: assert property (p_por) else $error("reset pair lost");
endmodule

// ==== serial_nand_deep_sleep_ctrl_test.sv ====
`timescale 1ns/1ps
module serial_nand_deep_sleep_ctrl_test;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic       cmd_valid = 1'b0;
    logic [7:0] cmd_byte = 8'h00;
    logic       array_busy = 1'b0;
    wire        cmd_ready, cmd_done, dev_busy, cmd_stb, soft_rst, por_rst, deep, blocked;
    wire        low_pwr;
    wire  [7:0] cmd_code;
    logic [9:0] notes[$];
    int         n_mismatch = 0;
    int         checks_done = 0;
    int         cycles = 0;

    sndp_if lnk ();
    sndp_host i_sndp_host (.CORE_CLK(clk), .NRST(nrst), .LINK(lnk), .CMD_VALID(cmd_valid),
        .CMD_BYTE(cmd_byte), .CMD_READY(cmd_ready), .CMD_DONE(cmd_done), .DEV_BUSY(dev_busy));
    sndp_dev i_sndp_dev (.CORE_CLK(clk), .NRST(nrst), .LINK(lnk), .ARRAY_BUSY(array_busy),
        .CMD_STB(cmd_stb), .CMD_CODE(cmd_code), .SOFT_RESET(soft_rst), .POR_RESET(por_rst),
        .DEEP_SLEEP(deep), .LOW_POWER(low_pwr), .CMD_BLOCKED(blocked));
    sndp_chk i_sndp_chk (.CORE_CLK(clk), .NRST(nrst), .cs_n(lnk.cs_n), .sclk_en(lnk.sclk_en),
        .sdi(lnk.sdi), .busy(lnk.busy), .CMD_STB(cmd_stb), .POR_RESET(por_rst),
        .DEEP_SLEEP(deep), .CMD_BLOCKED(blocked));

    initial forever #50 clk = ~clk;

    function automatic logic pwr(input logic [7:0] b);
        return b == 8'hb9 || b == 8'hab || b == 8'hff || b == 8'h66 || b == 8'h99;
    endfunction

    task automatic chk(input string nm, input logic [9:0] seen, input logic [9:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // one command frame; waits for the host to finish its gap
    task automatic send(input logic [7:0] b);
        while (!cmd_ready) @(negedge clk);
        cmd_valid = 1'b1;
        cmd_byte = b;
        @(negedge clk);
        cmd_valid = 1'b0;
        while (!cmd_done) @(negedge clk);
    endtask

    // entry delay is 30 cycles, 40 leaves margin
    task automatic sleep_now();
        send(8'hb9);
        repeat (40) @(negedge clk);
        chk("asleep", {8'h00, deep, low_pwr}, 10'h003);
    endtask

    // hang guard: whole run needs about 930 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // each pulse takes the oldest note; power commands forward nothing we rely on
    always @(negedge clk) begin
        if (nrst && (soft_rst || por_rst || (cmd_stb && !pwr(cmd_code)))) begin
            if (notes.size() == 0) chk("stray pulse", {soft_rst, por_rst, cmd_code}, 10'h000);
            else chk("pulse", (soft_rst || por_rst) ? {soft_rst, por_rst, 8'h00} : {2'b00, cmd_code}, notes.pop_front());
        end
    end

    initial begin
        logic [7:0] r;
        r = 8'($urandom(97298));
        repeat (3) @(negedge clk);
        nrst = 1'b1;
        for (int i = 0; i < 4; i++) begin
            do r = 8'($urandom); while (pwr(r));
            notes.push_back({2'b00, r});
            send(r);
        end
        chk("standby", {8'h00, deep, low_pwr}, 10'h000);
        array_busy = 1'b1;
        send(8'hb9);
        repeat (40) @(negedge clk);
        chk("busy sleep", {9'h000, deep}, 10'h000);
        chk("busy flag", {9'h000, dev_busy}, 10'h001);
        array_busy = 1'b0;
        sleep_now();
        send(8'h06);
        array_busy = 1'b1;
        send(8'hab);
        repeat (3) @(negedge clk);
        chk("busy wake", {9'h000, deep}, 10'h001);
        array_busy = 1'b0;
        send(8'hab);
        repeat (5) @(negedge clk);
        chk("woken", {8'h00, deep, blocked}, 10'h000);
        notes.push_back(10'h006);
        send(8'h06);
        sleep_now();
        notes.push_back(10'h200);
        send(8'hff);
        repeat (3) @(negedge clk);
        chk("soft wake", {9'h000, deep}, 10'h000);
        sleep_now();
        send(8'h66);
        notes.push_back(10'h100);
        send(8'h99);
        repeat (5) @(negedge clk);
        chk("pair wake", {9'h000, deep}, 10'h000);
        chk("notes left", 10'(notes.size()), 10'h000);
        report_and_stop();
    end
endmodule
